// [pmc_perf_monitor.sv]
`timescale 1ns/10ps
`include "pmc_consts.svh"
// Overview of operation
// - Eight-bit transmit slip count, one per event, zeroed when software reads it.
// - A slip event is one whole frame repeated or dropped by the transmit slip buffer.
// - Sixteen-bit zero violation count, accumulated, shown to software as two bytes.
// - Upper register shows count bits 15..8, lower register bits 7..0.
// - The count clears when the upper-then-lower read pair completes.
// - Eight-bit link 2 check error count, accumulated, zeroed when read.
// - Eight-bit link 3 check error count, accumulated, zeroed when read.
module pmc_perf_monitor
#(
   parameter int ADDR_WIDTH = `PMC_ADDR_WIDTH
)
(
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic [ADDR_WIDTH-1:0] addr_in,
   input wire logic [`PMC_BYTE_WIDTH-1:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic tx_slip_event_in,
   input wire logic zero_violation_event_in,
   input wire logic link2_check_error_in,
   input wire logic link3_check_error_in,
   output logic [`PMC_BYTE_WIDTH-1:0] rdata_out,
   output logic irq_out
);

   ////////////////////////////////////////////////////////////////////////////////
   // Elaboration checks

   // The printed offsets need the full channel address
   if (ADDR_WIDTH < `PMC_ADDR_WIDTH)
   begin : g_bad_addr
      $error("pmc_perf_monitor: address too narrow for register map");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations

   pmc_count_if #(.WIDTH(`PMC_SLIP_WIDTH)) slip_cnt ();
   pmc_count_if #(.WIDTH(`PMC_ZV_WIDTH)) zv_cnt ();
   pmc_count_if #(.WIDTH(`PMC_FCS_WIDTH)) link2_cnt ();
   pmc_count_if #(.WIDTH(`PMC_FCS_WIDTH)) link3_cnt ();

   pmc_pkg::pmc_pair_e pair_q;
   pmc_pkg::pmc_pair_e pair_d;
   logic [`PMC_ZV_WIDTH-1:0] zv_snap_q;
   pmc_pkg::pmc_byte_t rdata_q;
   pmc_pkg::pmc_byte_t rdata_d;
   pmc_pkg::pmc_byte_t irq_mask_q;
   pmc_pkg::pmc_byte_t irq_stat_q;
   pmc_pkg::pmc_byte_t irq_stat_d;
   pmc_pkg::pmc_byte_t ctrl_q;
   logic irq_q;
   pmc_pkg::pmc_src_s events;
   pmc_pkg::pmc_src_s wraps;
   pmc_pkg::pmc_src_s enables;

   logic rd_slip;
   logic rd_zv_high;
   logic rd_zv_low;
   logic rd_link2;
   logic rd_link3;
   logic rd_stat;
   logic rd_mask;
   logic rd_ctrl;
   logic wr_mask;
   logic wr_ctrl;
   logic zv_pair_done;

   ////////////////////////////////////////////////////////////////////////////////
   // Address decode

   // Each strobe qualifies exactly one register; unmapped reads return zero
   always_comb
   begin
      rd_slip = rd_in && (addr_in == ADDR_WIDTH'(`PMC_TX_SLIP_OFS));
      rd_zv_high = rd_in && (addr_in == ADDR_WIDTH'(`PMC_ZV_HIGH_OFS));
      rd_zv_low = rd_in && (addr_in == ADDR_WIDTH'(`PMC_ZV_LOW_OFS));
      rd_link2 = rd_in && (addr_in == ADDR_WIDTH'(`PMC_LINK2_OFS));
      rd_link3 = rd_in && (addr_in == ADDR_WIDTH'(`PMC_LINK3_OFS));
      rd_stat = rd_in && (addr_in == ADDR_WIDTH'(`PMC_IRQ_STAT_OFS));
      rd_mask = rd_in && (addr_in == ADDR_WIDTH'(`PMC_IRQ_MASK_OFS));
      rd_ctrl = rd_in && (addr_in == ADDR_WIDTH'(`PMC_CTRL_OFS));
      wr_mask = wr_in && (addr_in == ADDR_WIDTH'(`PMC_IRQ_MASK_OFS));
      wr_ctrl = wr_in && (addr_in == ADDR_WIDTH'(`PMC_CTRL_OFS));
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Event qualification

   // Disabled sources are dropped before they reach the counters or the status
   always_comb
   begin
      enables = pmc_pkg::pmc_src_s'(ctrl_q[`PMC_EVT_MSB:`PMC_EVT_LSB]);
      events.tx_slip = tx_slip_event_in && enables.tx_slip;
      events.zero_violation = zero_violation_event_in && enables.zero_violation;
      events.link2 = link2_check_error_in && enables.link2;
      events.link3 = link3_check_error_in && enables.link3;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Transmit slip counter

   // Whole-frame slips arrive as one pulse each; a read hands back and clears the count
   always_comb
   begin
      slip_cnt.inc = events.tx_slip;
      slip_cnt.clr = rd_slip;
      slip_cnt.sub = slip_cnt.count;
   end

   pmc_event_counter #(.WIDTH(`PMC_SLIP_WIDTH)) u_slip_counter
   (
      .clock_in(clock_in),
      .rst_n_in(rst_n_in),
      .cnt_io(slip_cnt)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Zero violation counter, read as an ordered byte pair

   // Pair tracker: the lower read only clears after an upper read opened the pair
   always_comb
   begin
      pair_d = pair_q;
      zv_pair_done = 1'b0;
      case (pair_q)
         pmc_pkg::PMC_PAIR_IDLE:
         begin
            if (rd_zv_high)
            begin
               pair_d = pmc_pkg::PMC_PAIR_HIGH_SEEN;
            end
         end
         pmc_pkg::PMC_PAIR_HIGH_SEEN:
         begin
            if (rd_zv_low)
            begin
               zv_pair_done = 1'b1;
               pair_d = pmc_pkg::PMC_PAIR_IDLE;
            end
         end
         default:
         begin
            pair_d = pmc_pkg::PMC_PAIR_IDLE;
         end
      endcase
   end

   // Pair state register
   always_ff @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         pair_q <= pmc_pkg::PMC_PAIR_IDLE;
      end
      else
      begin
         pair_q <= pair_d;
      end
   end

   // Freezing the whole value keeps the lower byte coherent with the upper one
   always_ff @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         zv_snap_q <= `PMC_ZV_RESET;
      end
      else if (rd_zv_high)
      begin
         zv_snap_q <= zv_cnt.count;
      end
   end

   // Clearing subtracts the frozen value, so events after the upper read are kept
   always_comb
   begin
      zv_cnt.inc = events.zero_violation;
      zv_cnt.clr = zv_pair_done;
      zv_cnt.sub = zv_snap_q;
   end

   pmc_event_counter #(.WIDTH(`PMC_ZV_WIDTH)) u_zv_counter
   (
      .clock_in(clock_in),
      .rst_n_in(rst_n_in),
      .cnt_io(zv_cnt)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Link check error counters

   // Link 2 frame check errors
   always_comb
   begin
      link2_cnt.inc = events.link2;
      link2_cnt.clr = rd_link2;
      link2_cnt.sub = link2_cnt.count;
   end

   pmc_event_counter #(.WIDTH(`PMC_FCS_WIDTH)) u_link2_counter
   (
      .clock_in(clock_in),
      .rst_n_in(rst_n_in),
      .cnt_io(link2_cnt)
   );

   // Link 3 frame check errors
   always_comb
   begin
      link3_cnt.inc = events.link3;
      link3_cnt.clr = rd_link3;
      link3_cnt.sub = link3_cnt.count;
   end

   pmc_event_counter #(.WIDTH(`PMC_FCS_WIDTH)) u_link3_counter
   (
      .clock_in(clock_in),
      .rst_n_in(rst_n_in),
      .cnt_io(link3_cnt)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt status, mask and control

   // Wrap pulses of all counters, in source order
   always_comb
   begin
      wraps.tx_slip = slip_cnt.wrap;
      wraps.zero_violation = zv_cnt.wrap;
      wraps.link2 = link2_cnt.wrap;
      wraps.link3 = link3_cnt.wrap;
   end

   // Sticky status: a read clears it, but a same-cycle event is set again
   always_comb
   begin
      irq_stat_d = rd_stat ? `PMC_STAT_RESET : irq_stat_q;
      irq_stat_d[`PMC_EVT_MSB:`PMC_EVT_LSB] = irq_stat_d[`PMC_EVT_MSB:`PMC_EVT_LSB] | events;
      irq_stat_d[`PMC_WRAP_MSB:`PMC_WRAP_LSB] = irq_stat_d[`PMC_WRAP_MSB:`PMC_WRAP_LSB] | wraps;
   end

   // Status register
   always_ff @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         irq_stat_q <= `PMC_STAT_RESET;
      end
      else
      begin
         irq_stat_q <= irq_stat_d;
      end
   end

   // Mask register, same layout as the status
   always_ff @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         irq_mask_q <= `PMC_MASK_RESET;
      end
      else if (wr_mask)
      begin
         irq_mask_q <= wdata_in;
      end
   end

   // Control register: low bits enable counting per source
   always_ff @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         ctrl_q <= `PMC_CTRL_RESET;
      end
      else if (wr_ctrl)
      begin
         ctrl_q <= wdata_in;
      end
   end

   // Level interrupt from the next status, so it falls with the clearing read
   always_ff @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         irq_q <= 1'b0;
      end
      else
      begin
         irq_q <= |(irq_stat_d & irq_mask_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read data path

   // Read mux; the value shown is the one the clear later removes
   always_comb
   begin
      rdata_d = `PMC_BYTE_RESET;
      if (rd_slip)
      begin
         rdata_d = slip_cnt.count;
      end
      else if (rd_zv_high)
      begin
         rdata_d = zv_cnt.count[`PMC_ZV_HIGH_MSB:`PMC_ZV_HIGH_LSB];
      end
      else if (rd_zv_low)
      begin
         // Outside a pair the live low byte is shown and nothing clears
         rdata_d = (pair_q == pmc_pkg::PMC_PAIR_HIGH_SEEN) ?
                   zv_snap_q[`PMC_ZV_LOW_MSB:`PMC_ZV_LOW_LSB] :
                   zv_cnt.count[`PMC_ZV_LOW_MSB:`PMC_ZV_LOW_LSB];
      end
      else if (rd_link2)
      begin
         rdata_d = link2_cnt.count;
      end
      else if (rd_link3)
      begin
         rdata_d = link3_cnt.count;
      end
      else if (rd_stat)
      begin
         rdata_d = irq_stat_q;
      end
      else if (rd_mask)
      begin
         rdata_d = irq_mask_q;
      end
      else if (rd_ctrl)
      begin
         rdata_d = ctrl_q;
      end
   end

   // Read data stands only in the cycle after the strobe, zero otherwise
   always_ff @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rdata_q <= `PMC_BYTE_RESET;
      end
      else
      begin
         rdata_q <= rd_in ? rdata_d : `PMC_BYTE_RESET;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign rdata_out = rdata_q;
   assign irq_out = irq_q;

endmodule // pmc_perf_monitor

// [pmc_consts.svh]
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH
// Bus and counter widths
`define PMC_ADDR_WIDTH 12
`define PMC_BYTE_WIDTH 8
`define PMC_SLIP_WIDTH 8
`define PMC_ZV_WIDTH 16
`define PMC_FCS_WIDTH 8
// Register offsets within the channel map
`define PMC_TX_SLIP_OFS 12'h90f
`define PMC_ZV_HIGH_OFS 12'h910
`define PMC_ZV_LOW_OFS 12'h911
`define PMC_LINK2_OFS 12'h91c
`define PMC_LINK3_OFS 12'h92c
`define PMC_IRQ_STAT_OFS 12'h930
`define PMC_IRQ_MASK_OFS 12'h931
`define PMC_CTRL_OFS 12'h932
// Reset values
`define PMC_BYTE_RESET 8'h00
`define PMC_ZV_RESET 16'h0000
`define PMC_MASK_RESET 8'h00
`define PMC_CTRL_RESET 8'h0f
`define PMC_STAT_RESET 8'h00
// Field positions of the split counter
`define PMC_ZV_HIGH_MSB 15
`define PMC_ZV_HIGH_LSB 8
`define PMC_ZV_LOW_MSB 7
`define PMC_ZV_LOW_LSB 0
// Field positions of status, mask and control
`define PMC_EVT_LSB 0
`define PMC_EVT_MSB 3
`define PMC_WRAP_LSB 4
`define PMC_WRAP_MSB 7
`define PMC_SRC_COUNT 4
`endif

// [pmc_pkg.sv]
package pmc_pkg;
   // One-hot progress of an ordered upper/lower read pair
   typedef enum logic [1:0]
   {
      PMC_PAIR_IDLE = 2'b01,
      PMC_PAIR_HIGH_SEEN = 2'b10
   } pmc_pair_e;

   // One bit per event source, high bit first
   typedef struct packed
   {
      logic link3;
      logic link2;
      logic zero_violation;
      logic tx_slip;
   } pmc_src_s;

   typedef logic [7:0] pmc_byte_t;
endpackage

// [pmc_count_if.sv]
`timescale 1ns/10ps
interface pmc_count_if #(parameter int WIDTH = 8);
   logic inc;
   logic clr;
   logic [WIDTH-1:0] sub;
   logic [WIDTH-1:0] count;
   logic wrap;
   modport counter (input inc, input clr, input sub, output count, output wrap);
   modport owner (output inc, output clr, output sub, input count, input wrap);
endinterface

// [pmc_event_counter.sv]
`timescale 1ns/10ps
`include "pmc_consts.svh"
module pmc_event_counter
#(
   parameter int WIDTH = 8
)
(
   input wire logic clock_in,
   input wire logic rst_n_in,
   pmc_count_if.counter cnt_io
);
   logic [WIDTH-1:0] count_q;
   logic [WIDTH-1:0] count_d;
   logic wrap_q;

   if (WIDTH < 1 || WIDTH > `PMC_ZV_WIDTH)
   begin : g_bad_width
      $error("pmc_event_counter: unsupported width");
   end

   // A clear removes only what software has been shown, so a same-cycle event survives
   always_comb
   begin
      count_d = cnt_io.clr ? WIDTH'(count_q - cnt_io.sub) : count_q;
      if (cnt_io.inc)
      begin
         count_d = WIDTH'(count_d + WIDTH'(1));
      end
   end

   // Count register, wraps modulo its width
   always_ff @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         count_q <= '0;
      end
      else
      begin
         count_q <= count_d;
      end
   end

   // Wrap pulse when an increment rolls the count to zero
   always_ff @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         wrap_q <= 1'b0;
      end
      else
      begin
         wrap_q <= cnt_io.inc && (count_d == '0);
      end
   end

   assign cnt_io.count = count_q;
   assign cnt_io.wrap = wrap_q;
endmodule // pmc_event_counter

// [pmc_check_monitor.sv]
`timescale 1ns/10ps
`include "pmc_consts.svh"
module pmc_check_monitor
#(
   parameter int ADDR_WIDTH = `PMC_ADDR_WIDTH
)
(
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic [ADDR_WIDTH-1:0] addr_in,
   input wire logic [`PMC_BYTE_WIDTH-1:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic tx_slip_event_in,
   input wire logic zero_violation_event_in,
   input wire logic link2_check_error_in,
   input wire logic link3_check_error_in,
   input wire logic [`PMC_BYTE_WIDTH-1:0] rdata_out,
   input wire logic irq_out
);
   logic [7:0] mask_q;
   logic [7:0] ctrl_q;
   // Read decodes; quiet means no event input is high
   wire logic rd_slip = rd_in && addr_in == `PMC_TX_SLIP_OFS;
   wire logic rd_hi = rd_in && addr_in == `PMC_ZV_HIGH_OFS;
   wire logic rd_lo = rd_in && addr_in == `PMC_ZV_LOW_OFS;
   wire logic rd_l2 = rd_in && addr_in == `PMC_LINK2_OFS;
   wire logic rd_l3 = rd_in && addr_in == `PMC_LINK3_OFS;
   wire logic rd_stat = rd_in && addr_in == `PMC_IRQ_STAT_OFS;
   wire logic rd_mask = rd_in && addr_in == `PMC_IRQ_MASK_OFS;
   wire logic rd_none = rd_in && !(rd_slip || rd_hi || rd_lo || rd_l2 || rd_l3 || rd_stat || rd_mask
      || addr_in == `PMC_CTRL_OFS);
   wire logic quiet = !(tx_slip_event_in || zero_violation_event_in || link2_check_error_in || link3_check_error_in);

   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!rst_n_in);

   // Shadow of mask and control, since the design shows them only through reads
   always_ff @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         mask_q <= `PMC_MASK_RESET;
         ctrl_q <= `PMC_CTRL_RESET;
      end
      else if (wr_in)
      begin
         if (addr_in == `PMC_IRQ_MASK_OFS) mask_q <= wdata_in;
         if (addr_in == `PMC_CTRL_OFS) ctrl_q <= wdata_in;
      end
   end

   ////////////////////////////////////////////////////////////
   idle_data_zero_a:
      assert property (!rd_in |=> rdata_out == 8'h00) else $error("read data not idle");
   slip_read_clear_a:
      assert property (rd_slip && !tx_slip_event_in ##1 rd_slip |=> rdata_out == 8'h00) else $error("slip not cleared");
   slip_read_keep_a:
      assert property (rd_slip && tx_slip_event_in ##1 rd_slip |=> rdata_out == {7'h00, ctrl_q[0]})
         else $error("slip in read cycle lost");
   link2_read_clear_a:
      assert property (rd_l2 && !link2_check_error_in ##1 rd_l2 |=> rdata_out == 8'h00) else $error("link2 not cleared");
   link3_read_clear_a:
      assert property (rd_l3 && !link3_check_error_in ##1 rd_l3 |=> rdata_out == 8'h00) else $error("link3 not cleared");
   pair_read_clear_a:
      assert property (rd_hi && !zero_violation_event_in ##1 rd_lo && !zero_violation_event_in ##1 rd_hi
         |=> rdata_out == 8'h00) else $error("pair read did not clear");
   unmapped_read_zero_a:
      assert property (rd_none |=> rdata_out == 8'h00) else $error("unmapped read not zero");
   mask_readback_a:
      assert property (rd_mask |=> rdata_out == mask_q) else $error("mask readback wrong");
   irq_mask_gate_a:
      assert property (irq_out |-> mask_q != 8'h00 || $past(mask_q) != 8'h00) else $error("irq while masked");
   // Quiet before the read too, since a wrap pulse lags its event by one cycle
   irq_status_clear_a:
      assert property (quiet ##1 rd_stat && quiet ##1 quiet |=> !irq_out) else $error("irq after status read");

   // Main scenarios
   cover property (rd_hi ##1 rd_lo);
   cover property (rd_slip && tx_slip_event_in);
   cover property ($rose(irq_out));
endmodule // pmc_check_monitor

bind pmc_perf_monitor pmc_check_monitor #(.ADDR_WIDTH(ADDR_WIDTH)) pmc_check_monitor_i
(
   .clock_in(clock_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
   .tx_slip_event_in(tx_slip_event_in), .zero_violation_event_in(zero_violation_event_in),
   .link2_check_error_in(link2_check_error_in), .link3_check_error_in(link3_check_error_in),
   .rdata_out(rdata_out), .irq_out(irq_out)
);

// [tb_top.sv]
`timescale 1ns/10ps
`include "pmc_consts.svh"
module tb_top;
   logic clock_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [11:0] addr_in = 12'h000;
   logic [7:0] wdata_in = 8'h00;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic [3:0] events = 4'h0;
   logic [7:0] rdata_out;
   logic irq_out;
   int miscompares = 0;
   int num_checks = 0;
   // Model state: counts, frozen pair value, writable registers, status
   int slip = 0, zv = 0, l2 = 0, l3 = 0, frz = 0, pair = 0;
   int mask = 0, ctrl = 15, stat = 0, i, pw = 0;
   logic [7:0] exp_rd = 8'h00;
   logic exp_irq = 1'b0;
   logic [31:0] lfsr = 32'hb590;
   logic [11:0] addrs [9] = '{`PMC_TX_SLIP_OFS, `PMC_ZV_HIGH_OFS, `PMC_ZV_LOW_OFS, `PMC_LINK2_OFS,
      `PMC_LINK3_OFS, `PMC_IRQ_STAT_OFS, `PMC_IRQ_MASK_OFS, `PMC_CTRL_OFS, 12'h9ff};
   int seq [12] = '{0, 0, 1, 2, 1, 2, 3, 3, 4, 4, 5, 5};

   pmc_perf_monitor pmc_perf_monitor_i
   (
      .clock_in(clock_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
      .rd_in(rd_in), .tx_slip_event_in(events[0]), .zero_violation_event_in(events[1]),
      .link2_check_error_in(events[2]), .link3_check_error_in(events[3]), .rdata_out(rdata_out), .irq_out(irq_out)
   );

   // Free-running 10 MHz clock
   initial
   begin
      forever #50 clock_in = ~clock_in;
   end

   ////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
   endfunction

   task automatic end_of_test;
      if (miscompares == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic check_byte(input string what, input pmc_pkg::pmc_byte_t exp, input pmc_pkg::pmc_byte_t got);
      num_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic check_bit(input string what, input logic exp, input logic got);
      num_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD %s expected %b seen %b", what, exp, got);
      end
   endtask

   // One bus cycle: drive, advance the model, then judge the previous cycle
   task automatic step(input logic rd, input logic wr, input logic [11:0] a, input logic [7:0] d, input logic [3:0] ev);
      int e;
      int rv;
      int nw;
      logic irq_n;
      @(posedge clock_in);
      rd_in <= rd;
      wr_in <= wr;
      addr_in <= a;
      wdata_in <= d;
      events <= ev;
      e = ev & ctrl;
      rv = 0;
      if (rd)
         case (a)
            `PMC_TX_SLIP_OFS: rv = slip;
            `PMC_ZV_HIGH_OFS: rv = zv >> 8;
            `PMC_ZV_LOW_OFS: rv = (pair ? frz : zv) & 255;
            `PMC_LINK2_OFS: rv = l2;
            `PMC_LINK3_OFS: rv = l3;
            `PMC_IRQ_STAT_OFS: rv = stat;
            `PMC_IRQ_MASK_OFS: rv = mask;
            `PMC_CTRL_OFS: rv = ctrl;
            default: rv = 0;
         endcase
      // Clear by subtracting what was returned, so same-cycle events survive
      if (rd && a == `PMC_TX_SLIP_OFS) slip = 0;
      if (rd && a == `PMC_LINK2_OFS) l2 = 0;
      if (rd && a == `PMC_LINK3_OFS) l3 = 0;
      if (rd && a == `PMC_ZV_LOW_OFS && pair) zv = (zv - frz) & 65535;
      if (rd && a == `PMC_ZV_HIGH_OFS) frz = zv;
      if (rd && (a == `PMC_ZV_HIGH_OFS || a == `PMC_ZV_LOW_OFS)) pair = (a == `PMC_ZV_HIGH_OFS);
      nw = {e[3] && l3 == 255, e[2] && l2 == 255, e[1] && zv == 65535, e[0] && slip == 255};
      slip = (slip + e[0]) % 256;
      zv = (zv + e[1]) % 65536;
      l2 = (l2 + e[2]) % 256;
      l3 = (l3 + e[3]) % 256;
      // Wrap flags land one cycle after the event, behind the counter's wrap register
      stat = ((rd && a == `PMC_IRQ_STAT_OFS) ? 0 : stat) | e | (pw << 4);
      pw = nw;
      irq_n = (stat & mask) != 0;
      if (wr && a == `PMC_IRQ_MASK_OFS) mask = d;
      if (wr && a == `PMC_CTRL_OFS) ctrl = d;
      @(negedge clock_in);
      check_byte("read data", exp_rd, rdata_out);
      // Interrupt follows the next status, so it is judged on every cycle
      check_bit("irq", exp_irq, irq_out);
      exp_irq = irq_n;
      exp_rd = rv[7:0];
   endtask

   // Reset values, random traffic, then wrap, ordered pairs and same-cycle events
   initial
   begin
      repeat (5) @(posedge clock_in);
      rst_n_in <= 1'b1;
      for (i = 0; i < 9; i++) step(1'b1, 1'b0, addrs[i], 8'h00, 4'h0);
      for (i = 0; i < 3000; i++)
      begin
         lfsr = lfsr_next(lfsr);
         step(lfsr[3:0] < 9, lfsr[3:0] == 9, addrs[lfsr[7:4] % 9], lfsr[15:8], lfsr[19:16] & lfsr[23:20]);
      end
      step(1'b0, 1'b1, `PMC_CTRL_OFS, 8'h0f, 4'h0);
      step(1'b0, 1'b1, `PMC_IRQ_MASK_OFS, 8'hff, 4'h0);
      repeat (300) step(1'b0, 1'b0, 12'h000, 8'h00, 4'h3);
      for (i = 0; i < 12; i++) step(1'b1, 1'b0, addrs[seq[i]], 8'h00, 4'h0);
      step(1'b1, 1'b0, `PMC_TX_SLIP_OFS, 8'h00, 4'h1);
      step(1'b1, 1'b0, `PMC_TX_SLIP_OFS, 8'h00, 4'h0);
      repeat (3) step(1'b0, 1'b0, 12'h000, 8'h00, 4'h0);
      end_of_test;
   end

   // Watchdog: tests take about 3300 cycles, allow roughly three times that
   initial
   begin
      #1000000;
      miscompares++;
      end_of_test;
   end
endmodule // tb_top
